// *** shared_timer_prescaler_pkg.sv ***
// constants, types and register layout of the shared timer prescaler
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - both timers share one divider, each with its own clock select field
// - clock select one advances the timer on every system clock cycle
// - divider runs freely, never affected by any clock select value
// - first prescaled count comes 1 to N+1 cycles after enabling
// - a divider reset restarts the period for every attached timer
// - external input sampled every cycle by synchroniser, then edge detected
// - synchroniser flops on rising edge, preceded by stage open while clock high
// - one count pulse per rising edge at select 7, falling at 6
// - pin edge reaches counter 1.5 to 2.5 system cycles later
// - external edges clock the timer directly, never divided
// - while hold bit 7 is one, written reset bits are kept; a kept bit 0 halts both timers
// - writing hold to zero clears both reset bits, timers restart together
// - bit 0 resets the divider and clears itself unless hold is set
// - select: 0 stop, 1..5 divide 1/8/64/256/1024, 6 fall, 7 rise
// - pin transitions count even when the pin is driven as output
package shared_timer_prescaler_pkg;
    localparam int unsigned NUM_TIMERS = 2;
    localparam int unsigned DIV_WIDTH = 10;
    localparam int unsigned IDX_WIDTH = 10;
    localparam int unsigned IDX_LSB = 2;
    // register indices; byte address is four times the index
    localparam logic [IDX_WIDTH-1:0] CTRL_INDEX = 10'h043;
    localparam logic [IDX_WIDTH-1:0] SEL_INDEX = 10'h044;
    localparam logic [IDX_WIDTH-1:0] STAT_INDEX = 10'h045;
    localparam int unsigned HOLD_BIT = 7;
    localparam int unsigned ASYNC_RST_BIT = 1;
    localparam int unsigned SYNC_RST_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int unsigned SEL_WIDTH = 3;
    localparam int unsigned SEL_STRIDE = 4;
    localparam int unsigned LVL_LSB = 16;
    localparam int unsigned HTRANS_ACTIVE_BIT = 1;
    localparam logic HRESP_OKAY = 1'b0;
    localparam logic [DIV_WIDTH-1:0] TAP8 = 10'h007;
    localparam logic [DIV_WIDTH-1:0] TAP64 = 10'h03f;
    localparam logic [DIV_WIDTH-1:0] TAP256 = 10'h0ff;
    localparam logic [DIV_WIDTH-1:0] TAP1024 = 10'h3ff;

    typedef enum logic [2:0] {
        CS_STOP = 3'h0,
        CS_DIV1 = 3'h1,
        CS_DIV8 = 3'h2,
        CS_DIV64 = 3'h3,
        CS_DIV256 = 3'h4,
        CS_DIV1024 = 3'h5,
        CS_EXT_FALL = 3'h6,
        CS_EXT_RISE = 3'h7
    } clk_sel_t;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_WRITE = 3'b010,
        BUS_LATE = 3'b100
    } bus_state_t;

    typedef struct packed {
        logic write;
        logic [IDX_WIDTH-1:0] index;
    } bus_req_t;

    typedef struct packed {
        logic hold;
        logic async_rst;
        logic sync_rst;
    } ctrl_t;
endpackage : shared_timer_prescaler_pkg

// *** ext_pin_sync.sv ***
// external count pin synchroniser and edge detector
`timescale 1ns/1ps
`default_nettype none
module ext_pin_sync (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic pin,
    output logic level,
    output logic rise,
    output logic fall
);
    import shared_timer_prescaler_pkg::*;

    logic stage_lo;
    logic stage_a;
    logic stage_b;

    ////////////////////////////////////////////////////////////////////////////
    // capture ending high phase
    // a falling-edge flop stands in for the latch open while the clock is high
    always_ff @(negedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stage_lo <= 1'b0;
        end else begin
            stage_lo <= pin;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stage_a <= 1'b0;
            stage_b <= 1'b0;
        end else begin
            stage_a <= stage_lo;
            stage_b <= stage_a;
        end
    end

    assign level = stage_b;
    assign rise = stage_a & ~stage_b;
    assign fall = ~stage_a & stage_b;

    AST_EDGE_EXCLUSIVE: assert property (@(posedge hclk) disable iff (!hresetn)
        !(rise && fall)) else $error("rise and fall detected together");
    AST_RISE_FROM_SAMPLE: assert property (@(posedge hclk) disable iff (!hresetn)
        rise |=> level) else $error("rise not followed by high level");
endmodule : ext_pin_sync
`default_nettype wire

// *** shared_timer_prescaler.sv ***
// shared prescaler, clock select and control register behind an ahb-lite slave
`timescale 1ns/1ps
`default_nettype none
module shared_timer_prescaler (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [shared_timer_prescaler_pkg::NUM_TIMERS-1:0] external_count_input,
    output logic [shared_timer_prescaler_pkg::NUM_TIMERS-1:0] timer_count_enable,
    output logic async_divider_reset
);
    import shared_timer_prescaler_pkg::*;

    bus_state_t state;
    bus_req_t req;
    ctrl_t ctrl;
    clk_sel_t clock_select_field [NUM_TIMERS];
    logic [DIV_WIDTH-1:0] div_cnt;
    logic [NUM_TIMERS-1:0] lvl;
    logic [NUM_TIMERS-1:0] rise;
    logic [NUM_TIMERS-1:0] fall;
    logic addr_ok;
    logic [IDX_WIDTH-1:0] addr_idx;
    logic wr_ctrl;
    logic wr_sel;
    logic read_now;
    logic late_read;
    logic [31:0] sel_word;
    logic [31:0] stat_word;
    logic [7:0] ctrl_word;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // count enable for one timer from its select and the shared divider
    function automatic logic next_enable(input logic [DIV_WIDTH-1:0] cnt,
                                         input clk_sel_t sel,
                                         input logic r,
                                         input logic f);
        logic hit;
        hit = 1'b0;
        unique case (sel)
            CS_STOP: hit = 1'b0;
            CS_DIV1: hit = 1'b1;
            CS_DIV8: hit = ((cnt & TAP8) == TAP8);
            CS_DIV64: hit = ((cnt & TAP64) == TAP64);
            CS_DIV256: hit = ((cnt & TAP256) == TAP256);
            CS_DIV1024: hit = ((cnt & TAP1024) == TAP1024);
            CS_EXT_FALL: hit = f;
            CS_EXT_RISE: hit = r;
        endcase
        return hit;
    endfunction : next_enable

    // read data for one register index; unmapped indices read zero
    function automatic logic [31:0] read_word(input logic [IDX_WIDTH-1:0] idx,
                                              input logic [7:0] c,
                                              input logic [31:0] s,
                                              input logic [31:0] st);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (idx == CTRL_INDEX) begin
            w = {24'h00_0000, c};
        end else if (idx == SEL_INDEX) begin
            w = s;
        end else if (idx == STAT_INDEX) begin
            w = st;
        end
        return w;
    endfunction : read_word

    ////////////////////////////////////////////////////////////////////////////
    // bus decode

    assign addr_ok = hsel & htrans[HTRANS_ACTIVE_BIT] & hready;
    assign addr_idx = haddr[IDX_LSB +: IDX_WIDTH];
    assign wr_ctrl = (state == BUS_WRITE) && (req.index == CTRL_INDEX);
    assign wr_sel = (state == BUS_WRITE) && (req.index == SEL_INDEX);
    // a read right behind a write waits one cycle so it sees the new value
    // only a pipelined master reaches this stall; one that idles between transfers never does
    assign late_read = addr_ok && !hwrite && (state == BUS_WRITE);
    assign read_now = addr_ok && !hwrite && (state != BUS_WRITE);

    always_comb begin
        ctrl_word = CTRL_RESET;
        ctrl_word[HOLD_BIT] = ctrl.hold;
        ctrl_word[ASYNC_RST_BIT] = ctrl.async_rst;
        ctrl_word[SYNC_RST_BIT] = ctrl.sync_rst;
    end

    always_comb begin
        sel_word = 32'h0000_0000;
        stat_word = 32'h0000_0000;
        for (int i = 0; i < NUM_TIMERS; i++) begin
            sel_word[i*SEL_STRIDE +: SEL_WIDTH] = clock_select_field[i];
        end
        stat_word[DIV_WIDTH-1:0] = div_cnt;
        stat_word[LVL_LSB +: NUM_TIMERS] = lvl;
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus state and address phase capture

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= BUS_IDLE;
        end else if (addr_ok && hwrite) begin
            state <= BUS_WRITE;
        end else if (late_read) begin
            state <= BUS_LATE;
        end else begin
            state <= BUS_IDLE;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req <= '0;
        end else if (addr_ok) begin
            req <= '{write: hwrite, index: addr_idx};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
        end else begin
            hreadyout <= !late_read;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (read_now) begin
            hrdata <= read_word(addr_idx, ctrl_word, sel_word, stat_word);
        end else if (state == BUS_LATE) begin
            hrdata <= read_word(req.index, ctrl_word, sel_word, stat_word);
        end
    end

    // every transfer completes with an okay response
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= HRESP_OKAY;
        end else begin
            hresp <= HRESP_OKAY;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control register

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl.hold <= CTRL_RESET[HOLD_BIT];
            ctrl.async_rst <= CTRL_RESET[ASYNC_RST_BIT];
            ctrl.sync_rst <= CTRL_RESET[SYNC_RST_BIT];
        end else if (wr_ctrl) begin
            ctrl.hold <= hwdata[HOLD_BIT];
            ctrl.async_rst <= hwdata[ASYNC_RST_BIT];
            ctrl.sync_rst <= hwdata[SYNC_RST_BIT];
        end else if (!ctrl.hold) begin
            ctrl.async_rst <= 1'b0;
            ctrl.sync_rst <= 1'b0;
        end
    end
    // hold keeps reset bits
    // the async reset bit only leaves the block for the third timer
    assign async_divider_reset = ctrl.async_rst;

    ////////////////////////////////////////////////////////////////////////////
    // clock select fields

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NUM_TIMERS; i++) begin
                clock_select_field[i] <= CS_STOP;
            end
        end else if (wr_sel) begin
            for (int i = 0; i < NUM_TIMERS; i++) begin
                clock_select_field[i] <= clk_sel_t'(hwdata[i*SEL_STRIDE +: SEL_WIDTH]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // shared divider

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_cnt <= '0;
        end else if (ctrl.sync_rst) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-timer clock source

    for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_timer
        // pad level, whatever the pin direction
        ext_pin_sync u_sync (
            .hclk(hclk),
            .hresetn(hresetn),
            .pin(external_count_input[t]),
            .level(lvl[t]),
            .rise(rise[t]),
            .fall(fall[t])
        );

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                timer_count_enable[t] <= 1'b0;
            end else if (ctrl.sync_rst) begin
                timer_count_enable[t] <= 1'b0;
            end else begin
                timer_count_enable[t] <= next_enable(div_cnt, clock_select_field[t],
                                                     rise[t], fall[t]);
            end
        end

        AST_STOP_SILENT: assert property (@(posedge hclk) disable iff (!hresetn)
            clock_select_field[t] == CS_STOP |=> !timer_count_enable[t])
            else $error("stopped timer got a count enable");

        AST_DIV1_EVERY: assert property (@(posedge hclk) disable iff (!hresetn)
            (clock_select_field[t] == CS_DIV1) && !ctrl.sync_rst
            |=> timer_count_enable[t])
            else $error("direct clock missed a cycle");

        AST_DIV8_TAP: assert property (@(posedge hclk) disable iff (!hresetn)
            (clock_select_field[t] == CS_DIV8) && !ctrl.sync_rst
            |=> timer_count_enable[t] == ($past(div_cnt[2:0]) == TAP8[2:0]))
            else $error("divide by eight tap wrong");

        AST_DIV8_SPACING: assert property (@(posedge hclk) disable iff (!hresetn)
            (clock_select_field[t] == CS_DIV8) && !ctrl.sync_rst
            && timer_count_enable[t]
            |=> !timer_count_enable[t] [*7])
            else $error("divide by eight enables too close");

        AST_EXT_RISE: assert property (@(posedge hclk) disable iff (!hresetn)
            (clock_select_field[t] == CS_EXT_RISE) && !ctrl.sync_rst
            |=> timer_count_enable[t] == $past(rise[t]))
            else $error("rising edge not passed as one pulse");

        AST_EXT_FALL: assert property (@(posedge hclk) disable iff (!hresetn)
            (clock_select_field[t] == CS_EXT_FALL) && !ctrl.sync_rst
            |=> timer_count_enable[t] == $past(fall[t]))
            else $error("falling edge not passed as one pulse");

        AST_EXT_LATENCY: assert property (@(posedge hclk) disable iff (!hresetn)
            ($past(clock_select_field[t]) == CS_EXT_RISE) && !$past(ctrl.sync_rst)
            && $rose(lvl[t]) |-> timer_count_enable[t])
            else $error("rising pin edge reached the counter late");

        AST_EXT_FALL_LATENCY: assert property (@(posedge hclk) disable iff (!hresetn)
            ($past(clock_select_field[t]) == CS_EXT_FALL) && !$past(ctrl.sync_rst)
            && $fell(lvl[t]) |-> timer_count_enable[t])
            else $error("falling pin edge reached the counter late");

        AST_HALT_ALL: assert property (@(posedge hclk) disable iff (!hresetn)
            ctrl.sync_rst |=> !timer_count_enable[t])
            else $error("count enable while divider reset held");

        AST_DIV64_TAP: assert property (@(posedge hclk) disable iff (!hresetn)
            (clock_select_field[t] == CS_DIV64) && !ctrl.sync_rst
            |=> timer_count_enable[t] == (($past(div_cnt) & TAP64) == TAP64))
            else $error("divide by sixty-four tap wrong");

        AST_DIV256_TAP: assert property (@(posedge hclk) disable iff (!hresetn)
            (clock_select_field[t] == CS_DIV256) && !ctrl.sync_rst
            |=> timer_count_enable[t] == (($past(div_cnt) & TAP256) == TAP256))
            else $error("divide by two hundred fifty-six tap wrong");

        AST_DIV1024_TAP: assert property (@(posedge hclk) disable iff (!hresetn)
            (clock_select_field[t] == CS_DIV1024) && !ctrl.sync_rst
            |=> timer_count_enable[t] == (($past(div_cnt) & TAP1024) == TAP1024))
            else $error("divide by one thousand twenty-four tap wrong");

        AST_SEL_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
            wr_sel |=> clock_select_field[t] == $past(hwdata[t*SEL_STRIDE +: SEL_WIDTH]))
            else $error("clock select not taken from written word");
    end

    ////////////////////////////////////////////////////////////////////////////
    // shared checks

    AST_FREE_RUN: assert property (@(posedge hclk) disable iff (!hresetn)
        !ctrl.sync_rst |=> div_cnt == $past(div_cnt) + 1'b1)
        else $error("divider did not advance");

    AST_DIV_RESET: assert property (@(posedge hclk) disable iff (!hresetn)
        ctrl.sync_rst |=> div_cnt == '0)
        else $error("divider not restarted by reset bit");

    AST_HOLD_KEEPS: assert property (@(posedge hclk) disable iff (!hresetn)
        ctrl.hold && ctrl.sync_rst && !wr_ctrl |=> ctrl.sync_rst && ctrl.hold)
        else $error("held reset bit was lost");

    AST_AUTO_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
        !ctrl.hold && !wr_ctrl |=> !ctrl.sync_rst && !ctrl.async_rst)
        else $error("reset bit not cleared by hardware");

    AST_RELEASE_TOGETHER: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_ctrl && !hwdata[HOLD_BIT] |=> ##1 !ctrl.sync_rst && !ctrl.async_rst)
        else $error("reset bits not released after hold cleared");

    AST_LATE_READ: assert property (@(posedge hclk) disable iff (!hresetn)
        late_read |=> !hreadyout ##1 hreadyout)
        else $error("read after write not stalled exactly one cycle");

    AST_OKAY_ONLY: assert property (@(posedge hclk) disable iff (!hresetn)
        hresp == HRESP_OKAY)
        else $error("slave answered with an error response");

    // a write never stalls, so back to back writes keep full rate
    AST_WRITE_ZERO_WAIT: assert property (@(posedge hclk) disable iff (!hresetn)
        state == BUS_WRITE |-> hreadyout)
        else $error("write data phase was stalled");
endmodule : shared_timer_prescaler
`default_nettype wire

// *** ext_pulse_source.sv ***
// pulse source model that drives one external count pin
`timescale 1ns/1ps
`default_nettype none
module ext_pulse_source (
    input wire logic start,
    input wire logic [3:0] edges,
    input wire logic [2:0] half,
    output logic pin,
    output logic busy
);
    initial begin
        pin = 1'b0;
        busy = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // the extra 7 ns lets the pin drift in phase against the system clock
    always @(posedge start) begin
        busy = 1'b1;
        repeat (edges) begin
            #(half * 40 + 7) pin = 1'b1;
            #(half * 40 + 7) pin = 1'b0;
        end
        #400 busy = 1'b0;
    end
endmodule : ext_pulse_source
`default_nettype wire

// *** testbench.sv ***
// self-checking bench for the shared timer prescaler
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
    $display("Error %0t: got %h want %h", $time, (a), (b)); end end
module testbench;
    import shared_timer_prescaler_pkg::*;
    localparam logic [31:0] A_CTRL = {20'h0, CTRL_INDEX, 2'b00};
    localparam logic [31:0] A_SEL = {20'h0, SEL_INDEX, 2'b00};
    localparam logic [31:0] A_STAT = {20'h0, STAT_INDEX, 2'b00};
    localparam logic [31:0] A_BAD = 32'h0000_0200;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, async_divider_reset;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, start, busy;
    logic [2:0] hsize, half;
    logic [3:0] edges;
    logic [NUM_TIMERS-1:0] external_count_input, timer_count_enable;
    int fails, check_count, seed, ctrl_model, sel_model, n, c0, c1;
    int divs[4] = '{8, 64, 256, 1024};
    assign hready = hreadyout;
    shared_timer_prescaler dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .external_count_input(external_count_input),
        .timer_count_enable(timer_count_enable), .async_divider_reset(async_divider_reset));
    ext_pulse_source src0 (.start(start[0]), .edges(edges), .half(half),
        .pin(external_count_input[0]), .busy(busy[0]));
    ext_pulse_source src1 (.start(start[1]), .edges(edges), .half(half),
        .pin(external_count_input[1]), .busy(busy[1]));
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        int w;
        w = 0;
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'h2;
        do begin @(posedge hclk); w++; end while (hreadyout !== 1'b1 && w < 50);
        htrans <= 2'b00;
        hwdata <= wd;
        do begin @(posedge hclk); w++; end while (hreadyout !== 1'b1 && w < 100);
        rd = hrdata;
        if (w >= 100) fails++;
    endtask : xfer
    // model: reset bits survive only under hold
    task automatic wr(input logic [31:0] a, input int v);
        xfer(1'b1, a, v);
        if (a == A_CTRL) ctrl_model = v[7] ? (v & 'h83) : 0;
        if (a == A_SEL) sel_model = v & 'h77;
    endtask : wr
    task automatic rchk(input logic [31:0] a, input logic [31:0] mask, input int exp);
        xfer(1'b0, a, 32'h0);
        `CHK(rd & mask, exp)
    endtask : rchk
    task automatic count_en(input int i, input int cyc, output int k);
        k = 0;
        // the enable is registered, so a new select shows one edge later
        @(posedge hclk);
        repeat (cyc) begin @(negedge hclk); k += (timer_count_enable[i] === 1'b1); end
        @(posedge hclk);
    endtask : count_en
    task automatic wait_pulse(input int i, input int lim, output int k);
        k = 0;
        do begin @(negedge hclk); k++; end while (timer_count_enable[i] !== 1'b1 && k < lim);
        @(posedge hclk);
    endtask : wait_pulse
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #(40 * 20000);
        fails++;
        wrap_up();
    end
    initial begin
        seed = 32'hcf97de80;
        {hresetn, hsel, hwrite, haddr, htrans, hwdata, start, edges} = '0;
        hsize = 3'h2;
        half = 3'h2;
        {fails, check_count, ctrl_model, sel_model} = '0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk(A_CTRL, 32'hffffffff, CTRL_RESET);
        rchk(A_SEL, 32'hffffffff, sel_model);
        rchk(A_BAD, 32'hffffffff, 0);
        `CHK(async_divider_reset, 1'b0)
        `CHK(hresp, HRESP_OKAY)
        xfer(1'b0, A_STAT, 32'h0);
        c0 = rd[9:0];
        xfer(1'b0, A_STAT, 32'h0);
        `CHK((int'(rd[9:0]) - c0 + 1024) % 1024, 2)
        $display("test reset and free divider done");
        wr(A_SEL, 32'h01);
        count_en(0, 32, n);
        `CHK(n, 32)
        count_en(1, 32, n);
        `CHK(n, 0)
        for (int m = 2; m <= 5; m++) begin
            wr(A_SEL, 0);
            wr(A_SEL, (m << 4) | m);
            wait_pulse(1, divs[m-2] + 2, c0);
            `CHK(c0 >= 1 && c0 <= divs[m-2] + 1, 1'b1)
            wait_pulse(1, divs[m-2] + 2, c0);
            `CHK(c0, divs[m-2])
        end
        $display("test divided selects done");
        wr(A_CTRL, 32'h81);
        rchk(A_CTRL, 32'hffffffff, ctrl_model);
        rchk(A_STAT, 32'h3ff, 0);
        wr(A_SEL, 32'h11);
        count_en(0, 20, n);
        `CHK(n, 0)
        wr(A_SEL, 32'h32);
        wr(A_CTRL, 32'h00);
        wait_pulse(0, 20, c0);
        wait_pulse(1, 100, c1);
        `CHK(c1, 56)
        `CHK(c0, divs[0] + 1)
        rchk(A_CTRL, 32'hffffffff, ctrl_model);
        wr(A_CTRL, 32'h01);
        // the written bit lives one cycle before hardware clears it
        @(posedge hclk);
        rchk(A_CTRL, 32'hffffffff, ctrl_model);
        wr(A_CTRL, 32'h82);
        repeat (2) @(posedge hclk);
        `CHK(async_divider_reset, 1'b1)
        rchk(A_CTRL, 32'hffffffff, ctrl_model);
        wr(A_CTRL, 32'h00);
        repeat (2) @(posedge hclk);
        `CHK(async_divider_reset, 1'b0)
        $display("test hold and divider reset done");
        // select changes only while the pins rest low
        wr(A_SEL, 32'h67);
        rchk(A_SEL, 32'hffffffff, sel_model);
        edges <= 4'($unsigned($random(seed)) % 8 + 3);
        half <= 3'($unsigned($random(seed)) % 4 + 2);
        start <= 2'b11;
        @(posedge hclk);
        start <= 2'b00;
        {c0, c1, n} = '0;
        do begin
            @(negedge hclk);
            c0 += (timer_count_enable[0] === 1'b1);
            c1 += (timer_count_enable[1] === 1'b1);
            n++;
        end while ((busy != 2'b00 || n < 20) && n < 3000);
        `CHK(c0, int'(edges))
        `CHK(c1, int'(edges))
        @(posedge hclk);
        edges <= 4'h1;
        half <= 3'h3;
        start <= 2'b01;
        @(posedge hclk);
        start <= 2'b00;
        @(posedge external_count_input[0]);
        n = 0;
        do begin @(negedge hclk); n++; end while (timer_count_enable[0] !== 1'b1 && n < 8);
        `CHK(n >= 2 && n <= 3, 1'b1)
        while (busy != 2'b00) @(posedge hclk);
        @(posedge hclk);
        rchk(A_STAT, 32'h30000, 0);
        $display("test external pin done");
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
